// [core_stack_model.sv]
// Purpose: core with return stack
// Assumes: next pc is set by the bench
// Notes:   empty stack shows inverse of next pc
`timescale 1ns/1ps
`default_nettype none
module core_stack_model #(
    parameter int DEPTH = 1
) (
    // clock
    input  wire logic               clk,
    // bench control
    input  wire logic [15:0]        pc_now,
    input  wire logic               ret_req,
    // controller side
    input  wire irq_pkg::core_out_t core_out,
    output irq_pkg::core_in_t       core_in
);
    // ------------------------------------------------------------
    // stack
    // ------------------------------------------------------------
    logic [15:0] mem [0:7];
    int          depth  = 0;
    logic        return_from_interrupt_q = 1'b0;
    logic [15:0] top;
    logic        full;
    always @(posedge clk) begin
        if (core_out.push) begin
            mem[depth] <= core_out.push_pc;
            depth      <= depth + 1;
        end else if (core_out.pop && depth > 0) begin
            depth <= depth - 1;
        end
        return_from_interrupt_q <= ret_req;
    end
    assign top     = (depth > 0) ? mem[depth - 1] : ~pc_now;
    assign full    = (depth + int'(core_out.push)) >= DEPTH;
    assign core_in = {pc_now, top, full, return_from_interrupt_q};
endmodule : core_stack_model
`default_nettype wire

// [irq_ctrl_sva.sv]
// Purpose: port checks of the controller
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to the top module
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_sva #(
    parameter logic [15:0] VEC_BASE = 16'h0004,
    parameter logic [15:0] VEC_STEP = 16'h0004
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // register port
    input wire logic [3:0]           addr,
    input wire logic [7:0]           wdata,
    input wire logic                 wr_en,
    input wire logic                 rd_en,
    input wire logic [7:0]           rdata,
    // sources and core
    input wire logic [1:0]           ext_pin,
    input wire irq_pkg::irq_events_t events,
    input wire irq_pkg::core_in_t    core_in,
    input wire irq_pkg::core_out_t   core_out,
    input wire logic                 wake
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_load;
        core_out.pc_load && !core_out.pop;
    endsequence
    sequence s_take;
        core_out.push ##1 s_load;
    endsequence
    take_order_a: assert property (core_out.push |-> s_take)
        else $error("no load after push");
    vector_value_a: assert property (s_load |-> core_out.pc_value >= VEC_BASE
        && core_out.pc_value < VEC_BASE + VEC_STEP * 16'hF
        && (core_out.pc_value - VEC_BASE) % VEC_STEP == 16'h0) else $error("bad vector");
    push_addr_a: assert property (core_out.push |-> core_out.push_pc == $past(core_in.next_pc))
        else $error("bad push pc");
    full_block_a: assert property (core_out.push |-> !$past(core_in.stack_full))
        else $error("take on full stack");
    ret_pop_a: assert property (core_out.pop |-> core_out.pc_load && $past(core_in.return_from_interrupt)
        && core_out.pc_value == $past(core_in.pop_pc)) else $error("bad return pc");
    push_pulse_a: assert property (core_out.push |=> !core_out.push ##1 !core_out.push)
        else $error("long push");
    read_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("stray rdata");
    unmapped_a: assert property ($past(rd_en) && $past(addr) > 4'h8 |-> rdata == 8'h00)
        else $error("unmapped nonzero");
    edge_bits_a: assert property ($past(rd_en) && $past(addr) == 4'h0 |-> rdata[7:4] == 4'h0)
        else $error("edge high bits");
    wake_rise_a: assert property (events != '0 |-> ##[1:2] wake)
        else $error("no wake");
endmodule : irq_ctrl_sva
bind irq_flag_enable_ctrl irq_ctrl_sva #(.VEC_BASE(VEC_BASE), .VEC_STEP(VEC_STEP)) irq_ctrl_sva_inst (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_pin(ext_pin), .events(events), .core_in(core_in), .core_out(core_out), .wake(wake));
`default_nettype wire

// [irq_flag_enable_ctrl.sv]
// Purpose: interrupt flags, enables, edge select and vectoring
// Assumes: core signals on the same clock
// Notes:   lowest index wins; vector is base plus index times step
//
// Behaviour
// - pin one edge field 3:2: 00 off, 01 rise, 10 fall, 11 both.
// - pin zero edge field 1:0, same encoding.
// - unimplemented bits read zero, ignore writes.
// - global enable, control 0 bit 0, blocks all when zero.
// - an event sets its flag whatever the enable.
// - flag with enable clear stays set, no vector jump.
// - flag, enable and global enable set redirect to the vector.
// - a take first pushes the next instruction address.
// - then the program counter loads the source vector.
// - return pops the saved address into the program counter.
// - ctrl 0 flags pin0, usb, card op 6:4; enables 3:1.
// - ctrl 1 flags card detect, uart1, uart0, pin1 7:4; enables 3:0.
// - ctrl 2 flags timebase1, timebase0, group1, group0 7:4; enables 3:0.
// - ctrl 3 flags group3, group2, spi1, spi0 7:4; enables 3:0.
// - group 0: compact timer match flags 7:4, enables 3:0.
// - group 1: standard and periodic timer match flags 7:4, enables 3:0.
// - group 2 low voltage 5, i2c 4, enables 1:0; eeprom variant adds 6 and 2.
// - group 3 adc 6, comparator one 5, zero 4, enables 2:0.
// - service clears global enable; new flags still recorded.
// - no take while the stack is full.
// - any set flag raises wake.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_enable_ctrl #(
    parameter bit                      EEPROM_VARIANT = 1'b0,
    parameter logic [irq_pkg::PC_W-1:0] VEC_BASE      = 16'h0004,
    parameter logic [irq_pkg::PC_W-1:0] VEC_STEP      = 16'h0004
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         nrst,
    // register port
    input  wire logic [irq_pkg::ADDR_W-1:0]   addr,
    input  wire logic [irq_pkg::DATA_W-1:0]   wdata,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    output logic      [irq_pkg::DATA_W-1:0]   rdata,
    // event sources
    input  wire logic [1:0]                   ext_pin,
    input  wire irq_pkg::irq_events_t         events,
    // core side
    input  wire irq_pkg::core_in_t            core_in,
    output irq_pkg::core_out_t                core_out,
    output logic                              wake
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (VEC_STEP == 16'h0000) begin : g_chk_step
        $error("vector step must be non-zero");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        irq_pkg::reg_file_t             regs;
        logic [irq_pkg::NUM_GRP-1:0]    grp_any;
        irq_pkg::ctrl_state_t           state;
        logic [irq_pkg::IDX_W-1:0]      idx;
        irq_pkg::core_out_t             core;
        logic [irq_pkg::DATA_W-1:0]     rdata;
        logic                           wake;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [1:0]                  rst_sync_q;
    logic                        rst_n;
    logic [1:0]                  pin_pulse;
    logic [irq_pkg::NUM_PRI-1:0] pf;
    logic [irq_pkg::NUM_PRI-1:0] pend;
    logic [irq_pkg::NUM_PRI-1:0] pev;
    logic [irq_pkg::NUM_GRP-1:0] grp_set;
    logic                        take;
    logic [irq_pkg::IDX_W-1:0]   pick;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // implemented bit masks
    function automatic logic [irq_pkg::DATA_W-1:0] wmask(
        input logic [irq_pkg::ADDR_W-1:0] a,
        input bit                         ee
    );
        case (a)
            irq_pkg::REG_EDGE:  return irq_pkg::MASK_EDGE;
            irq_pkg::REG_CTRL0: return irq_pkg::MASK_CTRL0;
            irq_pkg::REG_CTRL1: return irq_pkg::MASK_FULL;
            irq_pkg::REG_CTRL2: return irq_pkg::MASK_FULL;
            irq_pkg::REG_CTRL3: return irq_pkg::MASK_FULL;
            irq_pkg::REG_GRP0:  return irq_pkg::MASK_FULL;
            irq_pkg::REG_GRP1:  return irq_pkg::MASK_FULL;
            irq_pkg::REG_GRP2:  return ee ? irq_pkg::MASK_GRP2_EE : irq_pkg::MASK_GRP2;
            irq_pkg::REG_GRP3:  return irq_pkg::MASK_GRP3;
            default:            return irq_pkg::MASK_NONE;
        endcase
    endfunction : wmask

    function automatic logic [irq_pkg::NUM_PRI-1:0] pri_flags(input irq_pkg::reg_file_t r);
        return {r[irq_pkg::REG_CTRL3][7:4], r[irq_pkg::REG_CTRL2][7:4],
                r[irq_pkg::REG_CTRL1][7:4], r[irq_pkg::REG_CTRL0][6:4]};
    endfunction : pri_flags

    function automatic logic [irq_pkg::NUM_PRI-1:0] pri_enables(input irq_pkg::reg_file_t r);
        return {r[irq_pkg::REG_CTRL3][3:0], r[irq_pkg::REG_CTRL2][3:0],
                r[irq_pkg::REG_CTRL1][3:0], r[irq_pkg::REG_CTRL0][3:1]};
    endfunction : pri_enables

    function automatic irq_pkg::reg_file_t put_flags(
        input irq_pkg::reg_file_t          r,
        input logic [irq_pkg::NUM_PRI-1:0] v
    );
        irq_pkg::reg_file_t t;
        t = r;
        t[irq_pkg::REG_CTRL0][6:4] = v[2:0];
        t[irq_pkg::REG_CTRL1][7:4] = v[6:3];
        t[irq_pkg::REG_CTRL2][7:4] = v[10:7];
        t[irq_pkg::REG_CTRL3][7:4] = v[14:11];
        return t;
    endfunction : put_flags

    // lowest index wins
    function automatic logic [irq_pkg::IDX_W-1:0] first_set(
        input logic [irq_pkg::NUM_PRI-1:0] v
    );
        logic [irq_pkg::IDX_W-1:0] k;
        k = '0;
        for (int i = irq_pkg::NUM_PRI - 1; i >= 0; i--) begin
            if (v[i]) begin
                k = irq_pkg::IDX_W'(i);
            end
        end
        return k;
    endfunction : first_set

    // ----------------------------------------------------------------
    // external pins
    // ----------------------------------------------------------------
    pin_edge_detect u_pin0 (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (ext_pin[0]),
        .mode  (s_q.regs[irq_pkg::REG_EDGE][irq_pkg::PIN0_EDGE_LSB +: 2]),
        .pulse (pin_pulse[0])
    );

    pin_edge_detect u_pin1 (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (ext_pin[1]),
        .mode  (s_q.regs[irq_pkg::REG_EDGE][irq_pkg::PIN1_EDGE_LSB +: 2]),
        .pulse (pin_pulse[1])
    );

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    // enabled pending only
    assign pend = pri_flags(s_q.regs) & pri_enables(s_q.regs);
    assign pick = first_set(pend);
    assign take = (s_q.state == irq_pkg::ST_IDLE) & (|pend) & ~core_in.stack_full
                & s_q.regs[irq_pkg::REG_CTRL0][irq_pkg::GLOBAL_EN_BIT] & ~core_in.return_from_interrupt;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.core  = '0;
        s_d.rdata = '0;
        pf        = '0;
        pev       = '0;
        grp_set   = '0;

        if (rd_en) begin
            s_d.rdata = s_q.regs[addr] & wmask(addr, EEPROM_VARIANT);
        end

        if (wr_en && (addr < irq_pkg::ADDR_W'(irq_pkg::REG_CNT))) begin
            s_d.regs[addr] = wdata;
        end

        s_d.regs[irq_pkg::REG_GRP0][7:4] = s_d.regs[irq_pkg::REG_GRP0][7:4] | events.group0;
        s_d.regs[irq_pkg::REG_GRP1][7:4] = s_d.regs[irq_pkg::REG_GRP1][7:4] | events.group1;
        s_d.regs[irq_pkg::REG_GRP2][6:4] = s_d.regs[irq_pkg::REG_GRP2][6:4] | events.group2;
        s_d.regs[irq_pkg::REG_GRP3][6:4] = s_d.regs[irq_pkg::REG_GRP3][6:4] | events.group3;

        for (int i = 0; i < irq_pkg::REG_CNT; i++) begin
            s_d.regs[i] = s_d.regs[i] & wmask(irq_pkg::ADDR_W'(i), EEPROM_VARIANT);
        end

        // group flag on enabled sub flag
        for (int g = 0; g < irq_pkg::NUM_GRP; g++) begin
            s_d.grp_any[g] = |(s_d.regs[irq_pkg::REG_GRP0 + g][7:4]
                             & s_d.regs[irq_pkg::REG_GRP0 + g][3:0]);
        end
        grp_set = s_d.grp_any & ~s_q.grp_any;

        pev = {grp_set[3], grp_set[2], events.spi1, events.spi0,
               events.tb1, events.tb0, grp_set[1], grp_set[0],
               events.card_detect, events.uart1, events.uart0, pin_pulse[1],
               pin_pulse[0], events.usb, events.card_op};

        pf = pri_flags(s_d.regs);
        case (s_q.state)
            irq_pkg::ST_IDLE: begin
                if (take) begin
                    s_d.core.push    = 1'b1;
                    s_d.core.push_pc = core_in.next_pc;
                    s_d.idx          = pick;
                    s_d.state        = irq_pkg::ST_PUSH;
                    // service clears flag and global enable
                    pf[pick] = 1'b0;
                    s_d.regs[irq_pkg::REG_CTRL0][irq_pkg::GLOBAL_EN_BIT] = 1'b0;
                end else if (core_in.return_from_interrupt) begin
                    s_d.core.pop      = 1'b1;
                    s_d.core.pc_load  = 1'b1;
                    s_d.core.pc_value = core_in.pop_pc;
                end
            end
            irq_pkg::ST_PUSH: begin
                s_d.core.pc_load  = 1'b1;
                s_d.core.pc_value = VEC_BASE + irq_pkg::PC_W'(irq_pkg::PC_W'(s_q.idx) * VEC_STEP);
                s_d.state         = irq_pkg::ST_LOAD;
            end
            irq_pkg::ST_LOAD: begin
                s_d.state = irq_pkg::ST_IDLE;
            end
            default: begin
                s_d.state = irq_pkg::ST_IDLE;
            end
        endcase

        pf = pf | pev;
        s_d.regs = put_flags(s_d.regs, pf);

        s_d.wake = |pf;
        for (int i = 0; i < irq_pkg::NUM_GRP; i++) begin
            s_d.wake = s_d.wake | (|s_d.regs[irq_pkg::REG_GRP0 + i][7:4]);
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.regs    <= {irq_pkg::REG_CNT{irq_pkg::RESET_VAL}};
            s_q.state   <= irq_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata    = s_q.rdata;
    assign core_out = s_q.core;
    assign wake     = s_q.wake;

endmodule : irq_flag_enable_ctrl
`default_nettype wire

// [irq_pkg.sv]
// Purpose: constants and types of the controller
// Assumes: plain strobe register port
// Notes:   indices are register port addresses
package irq_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned REG_CNT = 9;
    localparam int unsigned PC_W    = 16;
    localparam int unsigned NUM_PRI = 15;
    localparam int unsigned NUM_GRP = 4;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned ARM_CYC = 2;

    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_EDGE  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL0 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CTRL1 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CTRL2 = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CTRL3 = 4'h4;
    localparam logic [ADDR_W-1:0] REG_GRP0  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_GRP1  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_GRP2  = 4'h7;
    localparam logic [ADDR_W-1:0] REG_GRP3  = 4'h8;

    // ----------------------------------------------------------------
    // implemented bits and reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] MASK_EDGE    = 8'h0F;
    localparam logic [DATA_W-1:0] MASK_CTRL0   = 8'h7F;
    localparam logic [DATA_W-1:0] MASK_FULL    = 8'hFF;
    localparam logic [DATA_W-1:0] MASK_GRP2    = 8'h33;
    localparam logic [DATA_W-1:0] MASK_GRP2_EE = 8'h77;
    localparam logic [DATA_W-1:0] MASK_GRP3    = 8'h77;
    localparam logic [DATA_W-1:0] MASK_NONE    = 8'h00;
    localparam logic [DATA_W-1:0] RESET_VAL    = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned GLOBAL_EN_BIT = 0;
    localparam int unsigned PIN0_EDGE_LSB = 0;
    localparam int unsigned PIN1_EDGE_LSB = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PUSH = 3'h2,
        ST_LOAD = 3'h4
    } ctrl_state_t;

    typedef logic [REG_CNT-1:0][DATA_W-1:0] reg_file_t;

    typedef struct packed {
        logic       usb;
        logic       card_op;
        logic       card_detect;
        logic       uart1;
        logic       uart0;
        logic       tb1;
        logic       tb0;
        logic       spi1;
        logic       spi0;
        logic [3:0] group0;
        logic [3:0] group1;
        logic [2:0] group2;
        logic [2:0] group3;
    } irq_events_t;

    typedef struct packed {
        logic [PC_W-1:0] next_pc;
        logic [PC_W-1:0] pop_pc;
        logic            stack_full;
        logic            return_from_interrupt;
    } core_in_t;

    typedef struct packed {
        logic            push;
        logic            pop;
        logic            pc_load;
        logic [PC_W-1:0] push_pc;
        logic [PC_W-1:0] pc_value;
    } core_out_t;

endpackage : irq_pkg

// [pin_edge_detect.sv]
// Purpose: pulse on the selected edge of one pin
// Assumes: pin is asynchronous to clk
// Notes:   edges ignored until the synchroniser refills
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pin and mode
    input  wire logic       pin,
    input  wire logic [1:0] mode,
    // event
    output logic            pulse
);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
        logic [1:0] arm;
        logic       pulse;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;
    logic        rise;
    logic        fall;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.s1   = pin;
        s_d.s2   = s_q.s1;
        s_d.prev = s_q.s2;
        s_d.arm  = {s_q.arm[0], 1'b1};
        rise     = s_q.s2 & ~s_q.prev & s_q.arm[1];
        fall     = ~s_q.s2 & s_q.prev & s_q.arm[1];
        case (irq_pkg::edge_mode_t'(mode))
            irq_pkg::EDGE_OFF:  s_d.pulse = 1'b0;
            irq_pkg::EDGE_RISE: s_d.pulse = rise;
            irq_pkg::EDGE_FALL: s_d.pulse = fall;
            irq_pkg::EDGE_BOTH: s_d.pulse = rise | fall;
            default:            s_d.pulse = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse = s_q.pulse;

endmodule : pin_edge_detect
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench of the controller
// Assumes: core model with a one-entry stack
// Notes:   tables and a stack queue give expectations
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                 clk = 1'b0;
    logic                 nrst = 1'b0;
    logic [3:0]           addr = 4'h0;
    logic [7:0]           wdata = 8'h00;
    logic                 wr_en = 1'b0;
    logic                 rd_en = 1'b0;
    logic [1:0]           ext_pin = 2'h0;
    logic [15:0]          pc_now = 16'h0;
    logic                 ret_req = 1'b0;
    irq_pkg::irq_events_t events = '0;
    irq_pkg::core_in_t    core_in;
    irq_pkg::core_out_t   core_out;
    logic [7:0]           rdata;
    logic                 wake;
    int                   fail_count = 0;
    int                   n_compared = 0;
    int                   n_push = 0;
    int                   cyc = 0;
    int                   base;
    logic [31:0]          rs = 32'd30;
    logic [7:0]           d;
    logic [7:0]           em;
    logic [15:0]          stk_q[$];
    localparam logic [15:0] VB = 16'h0100;
    localparam logic [15:0] VS = 16'h0008;
    logic [3:0] ta [15] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
    logic [7:0] tv [15] = '{8'h13, 8'h25, 8'h49, 8'h33, 8'h22, 8'h44, 8'h88, 8'h11, 8'h22, 8'h44, 8'h88,
                            8'h11, 8'h22, 8'h44, 8'h88};
    logic [7:0] ev [9]  = '{8'h00, 8'h30, 8'hE0, 8'hC0, 8'h30, 8'hF0, 8'hF0, 8'h30, 8'h70};
    logic [3:0] fr [2]  = '{4'h1, 4'h2};
    logic [7:0] fb [2]  = '{8'h40, 8'h10};

    always #12.5 clk = ~clk;

    irq_flag_enable_ctrl #(.EEPROM_VARIANT(1'b0), .VEC_BASE(VB), .VEC_STEP(VS)) irq_flag_enable_ctrl_inst (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_pin(ext_pin), .events(events), .core_in(core_in), .core_out(core_out), .wake(wake));
    core_stack_model #(.DEPTH(1)) core_stack_model_inst (
        .clk(clk), .pc_now(pc_now), .ret_req(ret_req), .core_out(core_out), .core_in(core_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (core_out.push === 1'b1) n_push++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    function automatic logic [7:0] msk(input int a);
        case (a)
            0: return irq_pkg::MASK_EDGE;
            1: return irq_pkg::MASK_CTRL0;
            7: return irq_pkg::MASK_GRP2;
            8: return irq_pkg::MASK_GRP3;
            default: return (a < 9) ? irq_pkg::MASK_FULL : irq_pkg::MASK_NONE;
        endcase
    endfunction : msk
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e}, "rdata");
    endtask : rd
    task automatic take_wait(input int idx);
        for (int k = 0; k < 12 && core_out.push !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(core_out.push), 16'h1, "push");
        chk(core_out.push_pc, pc_now, "push_pc");
        stk_q.push_back(pc_now);
        @(posedge clk);
        #1;
        chk(16'({core_out.pc_load, core_out.pop}), 16'h2, "load");
        chk(core_out.pc_value, VB + VS * 16'(idx), "vector");
    endtask : take_wait
    task automatic ret();
        logic [15:0] e;
        e = stk_q.pop_back();
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        for (int k = 0; k < 8 && core_out.pop !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(16'({core_out.pop, core_out.pc_load}), 16'h3, "pop");
        chk(core_out.pc_value, e, "return pc");
    endtask : ret
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 10; a++) rd(4'(a), 8'h00);
        for (int a = 0; a < 10; a++) begin
            em = (a == 1) ? 8'hFE : 8'hFF;
            d  = 8'(xs()) & em;
            wr(4'(a), em);
            rd(4'(a), em & msk(a));
            wr(4'(a), d);
            rd(4'(a), d & msk(a));
        end
        for (int a = 0; a < 9; a++) wr(4'(a), 8'h00);
        @(posedge clk);
        events <= '1;
        @(posedge clk);
        events <= '0;
        for (int a = 0; a < 9; a++) rd(4'(a), ev[a]);
        chk(16'(wake), 16'h1, "wake");
        chk(16'(n_push), 16'h0, "no take");
        for (int a = 0; a < 9; a++) wr(4'(a), 8'h00);
        repeat (2) @(posedge clk);
        chk(16'(wake), 16'h0, "wake low");
        wr(4'h6, 8'h01);
        @(posedge clk);
        events.group1 <= 4'h1;
        @(posedge clk);
        events.group1 <= 4'h0;
        rd(4'h6, 8'h11);
        rd(4'h3, 8'h20);
        wr(4'h6, 8'h00);
        wr(4'h3, 8'h00);
        base = n_push;
        wr(4'h1, 8'h24);
        repeat (8) @(posedge clk);
        wr(4'h1, 8'h21);
        repeat (8) @(posedge clk);
        chk(16'(n_push - base), 16'h0, "blocked");
        wr(4'h1, 8'h00);
        for (int i = 0; i < 15; i++) begin
            pc_now <= 16'(xs());
            wr(ta[i], tv[i]);
            if (ta[i] != 4'h1) wr(4'h1, 8'h01);
            take_wait(i);
            em = tv[i] & ~(8'h10 << ((i < 3) ? i : (i - 3) % 4)) & ((ta[i] == 4'h1) ? 8'hFE : 8'hFF);
            rd(ta[i], em);
            rd(4'h1, (ta[i] == 4'h1) ? em : 8'h00);
            ret();
            wr(ta[i], 8'h00);
        end
        pc_now <= 16'(xs());
        wr(4'h1, 8'h25);
        take_wait(1);
        base = n_push;
        wr(4'h1, 8'h13);
        repeat (8) @(posedge clk);
        chk(16'(n_push - base), 16'h0, "full stack");
        ret();
        take_wait(0);
        ret();
        wr(4'h1, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(4'h0, 8'(m << (2 * p)));
                @(posedge clk);
                ext_pin[p] <= 1'b1;
                repeat (8) @(posedge clk);
                rd(fr[p], m[0] ? fb[p] : 8'h00);
                wr(fr[p], 8'h00);
                @(posedge clk);
                ext_pin[p] <= 1'b0;
                repeat (8) @(posedge clk);
                rd(fr[p], m[1] ? fb[p] : 8'h00);
                wr(fr[p], 8'h00);
            end
        end
        summarize();
    end
endmodule : testbench
`default_nettype wire
